// File: logic/albs_sequencer.sv
// The register offsets and the address-and-strobe port were decided locally.
`timescale 1ns/1ps
module albs_sequencer import albs_pkg::*; #(
	parameter int unsigned UNIT_CYC = UNIT_CYC_DEF,
	parameter int unsigned BEEP_CYC = BEEP_CYC_DEF,
	parameter int unsigned W250_CYC = W250_CYC_DEF,
	parameter int unsigned W500_CYC = W500_CYC_DEF,
	parameter int unsigned W750_CYC = W750_CYC_DEF,
	parameter int unsigned W1000_CYC = W1000_CYC_DEF,
	parameter int unsigned W1250_CYC = W1250_CYC_DEF,
	parameter int unsigned W2500_CYC = W2500_CYC_DEF,
	parameter int unsigned W6000_CYC = W6000_CYC_DEF
) (
	// Clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// Register port
	input wire logic [3:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	output logic irq,
	// Enclosure fault levels
	input wire logic hw_err,
	input wire logic heartbeat_err,
	input wire logic iom_missing,
	input wire logic fan_fail,
	input wire logic psu0_fail,
	input wire logic psu1_fail,
	input wire logic temp_fail,
	input wire logic volt_fail,
	input wire logic fw_mismatch,
	input wire logic ctl_unrecov,
	input wire logic ctl_info,
	input wire logic ctl_noncrit,
	// Controller condition levels
	input wire logic ctl_init,
	input wire logic disk_fail,
	input wire logic rebuild_fail,
	input wire logic periph_fail,
	input wire logic rebuild_busy,
	input wire logic parity_busy,
	input wire logic drive_add_busy,
	// Notice triggers, taken on rising edge
	input wire logic peer_ctl_fail,
	input wire logic fw_dl_ok,
	input wire logic scan_blocked,
	input wire logic ld_not_good,
	// Buzzer
	output logic tone
);
	// Whole module state
	typedef struct packed {
		albs_state_e st;
		albs_pat_e pat;
		logic [TMR_W-1:0] tmr;
		logic [3:0] code;
		logic [3:0] elem;
		logic end_code;
		logic [2:0] step;
		logic rep;
		logic pend;
		logic tone;
		logic [1:0] kind;
		logic [NCOND-1:0] s1;
		logic [NCOND-1:0] s2;
		logic [NCOND-1:0] prev;
		logic [2:0] sts;
		logic [2:0] msk;
		logic en;
		logic [31:0] rdata;
	} albs_reg_s;

	albs_reg_s q, d;
	logic [NCOND-1:0] cond_raw; // Pins gathered for the synchroniser
	logic [NCODE-1:0] act; // Active Morse codes
	logic c_hw, c_hb, c_iom, c_fan, c_p0, c_p1, c_tmp, c_vlt, c_fw, c_unr, c_inf, c_nc;
	logic c_init, c_disk, c_rbf, c_per, c_rb, c_par, c_add;
	logic c_peer, c_dl, c_scan, c_ld;
	logic tw_rise; // Any notice trigger rose
	logic go_fault, go_busy; // Repeating pattern conditions

	assign cond_raw = {hw_err, heartbeat_err, iom_missing, fan_fail, psu0_fail, psu1_fail,
		temp_fail, volt_fail, fw_mismatch, ctl_unrecov, ctl_info, ctl_noncrit, ctl_init,
		disk_fail, rebuild_fail, periph_fail, rebuild_busy, parity_busy, drive_add_busy,
		peer_ctl_fail, fw_dl_ok, scan_blocked, ld_not_good};
	// Only the second synchroniser stage is read
	assign {c_hw, c_hb, c_iom, c_fan, c_p0, c_p1, c_tmp, c_vlt, c_fw, c_unr, c_inf, c_nc, c_init,
		c_disk, c_rbf, c_per, c_rb, c_par, c_add, c_peer, c_dl, c_scan, c_ld} = q.s2;

	// Active code vector in pass order
	always_comb begin
		act[1] = c_hw | c_hb | c_iom;
		act[2] = c_fan;
		act[3] = c_p0;
		act[4] = c_p1;
		act[5] = c_tmp;
		act[6] = c_vlt;
		act[7] = c_fw;
		act[8] = c_unr;
		act[9] = c_inf;
		act[10] = c_nc;
		act[0] = |act[8:1];
	end

	assign tw_rise = |({c_peer, c_dl, c_scan, c_ld} & ~q.prev[3:0]);
	assign go_fault = c_disk | c_rbf | c_per;
	assign go_busy = c_rb | c_par | c_add;

	// Tone length of one Morse element
	function automatic logic [TMR_W-1:0] el_cyc(input logic dash);
		return dash ? TMR_W'(3 * UNIT_CYC - 1) : TMR_W'(UNIT_CYC - 1);
	endfunction

	// Silence after a beep, per pattern and step
	function automatic logic [TMR_W-1:0] wait_cyc(input albs_pat_e p, input logic [2:0] s);
		int unsigned w;
		w = W250_CYC;
		unique case (p)
			P_INIT: w = W250_CYC;
			P_FAULT: w = (s == 3'h2) ? W2500_CYC : W750_CYC;
			P_BUSY: w = (s == 3'h1) ? W6000_CYC : W500_CYC;
			P_TWICE: begin
				unique case (s)
					3'h0: w = W250_CYC;
					3'h1: w = W500_CYC;
					3'h2: w = W750_CYC;
					3'h3: w = W1000_CYC;
					3'h4: w = W1250_CYC;
					default: w = W2500_CYC;
				endcase
			end
		endcase
		return TMR_W'(w - 1);
	endfunction

	// Index of the last beep of a pattern
	function automatic logic [2:0] last_step(input albs_pat_e p);
		logic [2:0] r;
		r = 3'h1;
		unique case (p)
			P_INIT: r = 3'h1;
			P_FAULT: r = 3'h2;
			P_BUSY: r = 3'h1;
			P_TWICE: r = 3'h5;
		endcase
		return r;
	endfunction

	// Next state
	always_comb begin
		albs_code_s cd;
		logic [4:0] nx;
		logic wr_sts;
		logic [2:0] ev;
		cd = albs_code(q.code);
		nx = 5'h00;
		wr_sts = reg_wr && (reg_addr == OFS_STATUS);
		ev = 3'h0;
		d = q;
		d.s1 = cond_raw;
		d.s2 = q.s1;
		d.prev = q.s2;
		d.rdata = 32'h0;
		if (q.tmr != '0) begin
			d.tmr = q.tmr - TMR_W'(1);
		end
		unique case (q.st)
			// Choose what to play, Morse pass first
			S_IDLE: begin
				if (|act) begin
					nx = albs_next(act, CD_CRIT);
					cd = albs_code(nx[3:0]);
					d.code = nx[3:0];
					d.elem = 4'h0;
					d.st = S_MTONE;
					d.tmr = el_cyc(cd.dash[0]);
					d.kind = cd.dash[0] ? K_DASH : K_DOT;
				end else if (c_init || go_fault || go_busy || q.pend) begin
					d.st = S_NBEEP;
					d.step = 3'h0;
					d.tmr = TMR_W'(BEEP_CYC - 1);
					d.kind = K_BEEP;
					if (c_init) begin
						d.pat = P_INIT;
					end else if (go_fault) begin
						d.pat = P_FAULT;
					end else if (go_busy) begin
						d.pat = P_BUSY;
					end else begin
						d.pat = P_TWICE;
						d.pend = 1'b0;
						d.rep = 1'b1;
					end
				end
			end
			// Element sounding
			S_MTONE: begin
				if (q.tmr == '0) begin
					d.st = S_MGAP;
					if (q.elem == cd.len - 4'h1) begin
						d.end_code = 1'b1;
						d.tmr = TMR_W'(3 * UNIT_CYC - 1);
					end else begin
						d.end_code = 1'b0;
						d.tmr = cd.gap[q.elem] ? TMR_W'(3 * UNIT_CYC - 1)
							: TMR_W'(UNIT_CYC - 1);
					end
				end
			end
			// Silence after an element or a code
			S_MGAP: begin
				if (q.tmr == '0) begin
					if (!q.end_code) begin
						d.elem = q.elem + 4'h1;
						d.st = S_MTONE;
						d.tmr = el_cyc(cd.dash[d.elem]);
						d.kind = cd.dash[d.elem] ? K_DASH : K_DOT;
					end else begin
						nx = albs_next(act, q.code + 4'h1);
						if (nx[4]) begin
							cd = albs_code(nx[3:0]);
							d.code = nx[3:0];
							d.elem = 4'h0;
							d.st = S_MTONE;
							d.tmr = el_cyc(cd.dash[0]);
							d.kind = cd.dash[0] ? K_DASH : K_DOT;
						end else begin
							d.st = S_IDLE;
							ev[ST_WRAP] = 1'b1;
						end
					end
				end
			end
			// Fixed quarter-second beep
			S_NBEEP: begin
				if (q.tmr == '0) begin
					d.st = S_NWAIT;
					d.tmr = wait_cyc(q.pat, q.step);
				end
			end
			// Silence after a beep
			S_NWAIT: begin
				if (q.tmr == '0) begin
					if (q.step == last_step(q.pat)) begin
						if (q.pat == P_TWICE && q.rep) begin
							d.rep = 1'b0;
							d.step = 3'h0;
							d.st = S_NBEEP;
							d.tmr = TMR_W'(BEEP_CYC - 1);
						end else begin
							d.st = S_IDLE;
							ev[ST_TWICE] = (q.pat == P_TWICE);
						end
					end else begin
						d.step = q.step + 3'h1;
						d.st = S_NBEEP;
						d.tmr = TMR_W'(BEEP_CYC - 1);
					end
				end
			end
		endcase
		// A new trigger wins over the clear at play start
		if (tw_rise) begin
			d.pend = 1'b1;
		end
		// Muted sequencer rests in idle
		if (!q.en) begin
			d.st = S_IDLE;
		end
		d.tone = (d.st == S_MTONE) || (d.st == S_NBEEP);
		ev[ST_NEW] = |(q.s2 & ~q.prev);
		// Sticky status, set wins over write-one-to-clear
		d.sts = (q.sts & ~(wr_sts ? reg_wdata[2:0] : 3'h0)) | ev;
		if (reg_wr && reg_addr == OFS_MASK) begin
			d.msk = reg_wdata[2:0];
		end
		if (reg_wr && reg_addr == OFS_CTRL) begin
			d.en = reg_wdata[0];
		end
		// Read data for the next cycle only
		if (reg_rd) begin
			unique case (reg_addr)
				OFS_STATUS: d.rdata = {29'h0, q.sts};
				OFS_MASK: d.rdata = {29'h0, q.msk};
				OFS_CTRL: d.rdata = {31'h0, q.en};
				OFS_STATE: d.rdata = {13'h0, 3'(q.st), act, q.code, q.tone};
				default: d.rdata = 32'h0;
			endcase
		end
	end

	// State register
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			q <= '{st: S_IDLE, pat: P_INIT, tmr: '0, code: 4'h0, elem: 4'h0, end_code: 1'b0,
				step: 3'h0, rep: 1'b0, pend: 1'b0, tone: 1'b0, kind: K_DOT, s1: '0, s2: '0,
				prev: '0, sts: STATUS_RST, msk: MASK_RST, en: CTRL_EN_RST, rdata: 32'h0};
		end else begin
			q <= d;
		end
	end

	assign tone = q.tone;
	assign reg_rdata = q.rdata;
	assign irq = |(q.sts & q.msk);

	// Next active code after the one playing; bit 4 says one exists
	logic [4:0] nx_more;
	assign nx_more = albs_next(act, q.code + 4'h1);

	// Helper counters for checking tone and gap lengths
	logic [31:0] on_cnt;
	logic [31:0] gap_cnt;
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			on_cnt <= 32'h0;
			gap_cnt <= 32'h0;
		end else begin
			on_cnt <= q.tone ? on_cnt + 32'h1 : 32'h0;
			gap_cnt <= (q.st == S_MGAP) ? gap_cnt + 32'h1 : 32'h0;
		end
	end

	dot_length_a: assert property (@(posedge clk) disable iff (!arst_n)
		($fell(q.tone) && q.en && q.kind == K_DOT) |-> on_cnt == UNIT_CYC)
		else $error("dot length wrong");
	dash_length_a: assert property (@(posedge clk) disable iff (!arst_n)
		($fell(q.tone) && q.en && q.kind == K_DASH) |-> on_cnt == 3 * UNIT_CYC)
		else $error("dash length wrong");
	beep_length_a: assert property (@(posedge clk) disable iff (!arst_n)
		($fell(q.tone) && q.en && q.kind == K_BEEP) |-> on_cnt == BEEP_CYC)
		else $error("beep length wrong");
	crit_first_a: assert property (@(posedge clk) disable iff (!arst_n)
		(q.st == S_IDLE && q.en && act[0]) |=> (q.st == S_MTONE && q.code == CD_CRIT))
		else $error("pass did not open with critical code");
	pass_restart_a: assert property (@(posedge clk) disable iff (!arst_n)
		(q.st == S_MGAP && q.tmr == '0 && q.end_code && q.en && !nx_more[4] && (|act))
		##1 (q.en && (|act))
		|-> q.st == S_IDLE ##1 (q.st == S_MTONE && q.tone))
		else $error("pass did not restart");
	morse_gap_a: assert property (@(posedge clk) disable iff (!arst_n)
		(q.st == S_MTONE && $past(q.st) == S_MGAP)
		|-> (gap_cnt == UNIT_CYC || gap_cnt == 3 * UNIT_CYC))
		else $error("element gap wrong");
	event_code_a: assert property (@(posedge clk) disable iff (!arst_n)
		(q.st == S_IDLE && q.en && (c_hw || c_hb || c_iom))
		|=> (q.st == S_MTONE && q.code <= CD_EVENT))
		else $error("event letter missing");
	init_pattern_a: assert property (@(posedge clk) disable iff (!arst_n)
		(q.st == S_IDLE && q.en && !(|act) && c_init)
		|=> (q.st == S_NBEEP && q.pat == P_INIT && q.tone)[*2])
		else $error("init pattern not started");
endmodule

// File: logic/albs_pkg.sv
// How it works
// - Dot sounds for one base unit.
// - Dash sounds for three base units.
// - Pass opens with critical code when a code from E to SOS is active, then failures.
// - Finished pass restarts while conditions remain.
// - Component letters E F P0 P1 T V R SOS.
// - Eight dashes, dash-three-dots-dash, eight dots.
// - Event letter from hardware, heartbeat, missing module.
// - Controller beeps last a quarter second.
// - Initialization: beep, 0.25 s, beep, 0.25 s.
// - Disk/rebuild/peripheral fail: 0.75, 0.75, 2.5 s waits.
// - Rebuild in progress: beep, 0.5 s, beep, 6 s.
// - Notice pattern with rising waits plays twice.
package albs_pkg;
	// Clock rate and derived cycles per millisecond
	localparam int unsigned CLK_HZ = 10_000_000;
	localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
	// Times in milliseconds
	localparam int unsigned UNIT_MS = 100;
	localparam int unsigned BEEP_MS = 250;
	localparam int unsigned W250_MS = 250;
	localparam int unsigned W500_MS = 500;
	localparam int unsigned W750_MS = 750;
	localparam int unsigned W1000_MS = 1000;
	localparam int unsigned W1250_MS = 1250;
	localparam int unsigned W2500_MS = 2500;
	localparam int unsigned W6000_MS = 6000;
	// Default cycle counts
	localparam int unsigned UNIT_CYC_DEF = UNIT_MS * CYC_PER_MS;
	localparam int unsigned BEEP_CYC_DEF = BEEP_MS * CYC_PER_MS;
	localparam int unsigned W250_CYC_DEF = W250_MS * CYC_PER_MS;
	localparam int unsigned W500_CYC_DEF = W500_MS * CYC_PER_MS;
	localparam int unsigned W750_CYC_DEF = W750_MS * CYC_PER_MS;
	localparam int unsigned W1000_CYC_DEF = W1000_MS * CYC_PER_MS;
	localparam int unsigned W1250_CYC_DEF = W1250_MS * CYC_PER_MS;
	localparam int unsigned W2500_CYC_DEF = W2500_MS * CYC_PER_MS;
	localparam int unsigned W6000_CYC_DEF = W6000_MS * CYC_PER_MS;
	localparam int TMR_W = 27;
	// Register offsets and reset values
	localparam logic [3:0] OFS_STATUS = 4'h0;
	localparam logic [3:0] OFS_MASK = 4'h4;
	localparam logic [3:0] OFS_CTRL = 4'h8;
	localparam logic [3:0] OFS_STATE = 4'hc;
	localparam logic [2:0] STATUS_RST = 3'h0;
	localparam logic [2:0] MASK_RST = 3'h0;
	localparam logic CTRL_EN_RST = 1'b1;
	// Status bit positions
	localparam int ST_WRAP = 0;
	localparam int ST_TWICE = 1;
	localparam int ST_NEW = 2;
	// Code numbers, in pass order
	localparam int NCODE = 11;
	localparam logic [3:0] CD_CRIT = 4'h0;
	localparam logic [3:0] CD_EVENT = 4'h1;
	localparam logic [3:0] CD_LAST_COMP = 4'h8;
	// Condition input count
	localparam int NCOND = 23;
	// Tone kinds
	localparam logic [1:0] K_DOT = 2'h0;
	localparam logic [1:0] K_DASH = 2'h1;
	localparam logic [1:0] K_BEEP = 2'h2;
	// Sequencer states
	typedef enum logic [2:0] {S_IDLE, S_MTONE, S_MGAP, S_NBEEP, S_NWAIT} albs_state_e;
	// Non-Morse patterns
	typedef enum logic [1:0] {P_INIT, P_FAULT, P_BUSY, P_TWICE} albs_pat_e;
	// One code: element count, dash mask, letter-gap-after mask
	typedef struct packed {
		logic [3:0] len;
		logic [8:0] dash;
		logic [8:0] gap;
	} albs_code_s;
	// Element patterns, bit 0 sounds first
	function automatic albs_code_s albs_code(input logic [3:0] idx);
		albs_code_s c;
		c = '{len: 4'h1, dash: 9'h000, gap: 9'h000};
		unique case (idx)
			4'h0: c = '{len: 4'h8, dash: 9'h0ff, gap: 9'h000};
			4'h1: c = '{len: 4'h1, dash: 9'h000, gap: 9'h000};
			4'h2: c = '{len: 4'h4, dash: 9'h004, gap: 9'h000};
			4'h3: c = '{len: 4'h9, dash: 9'h1f6, gap: 9'h008};
			4'h4: c = '{len: 4'h9, dash: 9'h1e6, gap: 9'h008};
			4'h5: c = '{len: 4'h1, dash: 9'h001, gap: 9'h000};
			4'h6: c = '{len: 4'h4, dash: 9'h008, gap: 9'h000};
			4'h7: c = '{len: 4'h3, dash: 9'h002, gap: 9'h000};
			4'h8: c = '{len: 4'h9, dash: 9'h038, gap: 9'h024};
			4'h9: c = '{len: 4'h5, dash: 9'h011, gap: 9'h000};
			4'ha: c = '{len: 4'h8, dash: 9'h000, gap: 9'h000};
			default: c = '{len: 4'h1, dash: 9'h000, gap: 9'h000};
		endcase
		return c;
	endfunction
	// First active code at or above a start index
	function automatic logic [4:0] albs_next(input logic [NCODE-1:0] act, input logic [3:0] from);
		logic [4:0] r;
		r = 5'h00;
		for (int i = NCODE - 1; i >= 0; i--) begin
			if (act[i] && (4'(i) >= from)) begin
				r = {1'b1, 4'(i)};
			end
		end
		return r;
	endfunction
endpackage

// File: bench/albs_buzzer_model.sv
`timescale 1ns/1ps
module albs_buzzer_model (
	// Clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// Buzzer drive from the sequencer
	input wire logic tone
);
	// Run lengths heard: positive for sound, negative for silence
	int runs[$];
	// Length of the run in progress
	int cnt;
	// Level seen on the previous edge
	logic prev;

	// A run is logged when the level flips, so an unknown also ends a run
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cnt = 0;
			prev = 1'b0;
		end else begin
			if (tone !== prev) begin
				runs.push_back(prev ? cnt : -cnt);
				cnt = 1;
			end else begin
				cnt++;
			end
			prev = tone;
		end
	end
endmodule

// File: bench/alarm_beep_sequencer_tb.sv
`timescale 1ns/1ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin n_fail++; \
	$display("[ERR] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module alarm_beep_sequencer_tb import albs_pkg::*;;
	localparam int U = 4; // Morse unit in cycles
	localparam int BP = 5; // Controller beep in cycles
	// Controller silences in cycles, shortest first
	localparam int W25 = 3;
	localparam int W50 = 6;
	localparam int W75 = 7;
	localparam int W100 = 8;
	localparam int W125 = 9;
	localparam int W250 = 10;
	localparam int W600 = 12;
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	logic [3:0] reg_addr = 4'h0;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [31:0] reg_rdata;
	logic irq;
	logic tone;
	logic [22:0] cnd = 23'h0; // Condition inputs in port order
	int n_fail = 0;
	int total_checks = 0;
	int cyc = 0;
	int exp_q[$]; // Expected runs of one pass
	// Element patterns: crit, E, F, P0, P1, T, V, R, SOS, info, noncrit; bar is a letter gap
	string codes[11] = '{"--------", ".", "..-.", ".--.|-----", ".--.|.----", "-", "...-",
		".-.", "...|---|...", "-...-", "........"};

	// Clock at 10 MHz
	always #50 clk = ~clk;

	albs_sequencer #(.UNIT_CYC(U), .BEEP_CYC(BP), .W250_CYC(W25), .W500_CYC(W50),
		.W750_CYC(W75), .W1000_CYC(W100), .W1250_CYC(W125), .W2500_CYC(W250),
		.W6000_CYC(W600)) dut_u (
		.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
		.hw_err(cnd[0]), .heartbeat_err(cnd[1]), .iom_missing(cnd[2]), .fan_fail(cnd[3]),
		.psu0_fail(cnd[4]), .psu1_fail(cnd[5]), .temp_fail(cnd[6]), .volt_fail(cnd[7]),
		.fw_mismatch(cnd[8]), .ctl_unrecov(cnd[9]), .ctl_info(cnd[10]), .ctl_noncrit(cnd[11]),
		.ctl_init(cnd[12]), .disk_fail(cnd[13]), .rebuild_fail(cnd[14]), .periph_fail(cnd[15]),
		.rebuild_busy(cnd[16]), .parity_busy(cnd[17]), .drive_add_busy(cnd[18]),
		.peer_ctl_fail(cnd[19]), .fw_dl_ok(cnd[20]), .scan_blocked(cnd[21]),
		.ld_not_good(cnd[22]), .tone(tone));

	albs_buzzer_model buz_u (.clk(clk), .arst_n(arst_n), .tone(tone));

	// Cuts a hang short
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			n_fail++;
			end_of_test();
		end
	end

	// Appends one code's runs; a code after the first in the queue starts after a letter gap
	function automatic void add_code(input string s);
		logic g;
		g = 1'b1;
		for (int i = 0; i < s.len(); i++) begin
			if (s[i] == "|") begin
				g = 1'b1;
			end else begin
				if (exp_q.size() > 0) begin
					exp_q.push_back(g ? -3 * U : -U);
				end
				exp_q.push_back(s[i] == "-" ? 3 * U : U);
				g = 1'b0;
			end
		end
	endfunction

	// One write cycle
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask

	// One read cycle, data compared in the cycle after the strobe
	task automatic rd_chk(input logic [3:0] a, input logic [31:0] e);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(negedge clk);
		`CHK(reg_rdata, e)
	endtask

	// Waits for a long silence, then forgets the runs heard so far
	task automatic quiet();
		int k;
		k = 0;
		while (!(buz_u.prev === 1'b0 && buz_u.cnt >= 40) && k < 3000) begin
			@(posedge clk);
			k++;
		end
		buz_u.runs.delete();
	endtask

	// Compares reps passes; entry 0 is the idle time and the wrap gap is skipped
	task automatic check_runs(input int reps);
		int n;
		int k;
		n = exp_q.size();
		k = 0;
		while (buz_u.runs.size() < reps * (n + 1) && k < 20000) begin
			@(posedge clk);
			k++;
		end
		for (int p = 0; p < reps; p++) begin
			for (int i = 0; i < n; i++) begin
				`CHK(buz_u.runs[1 + p * (n + 1) + i], exp_q[i])
			end
		end
	endtask

	// Morse pass for a set of codes; the event letter comes from one of three sources
	task automatic morse(input logic [10:1] m, input int src);
		quiet();
		exp_q.delete();
		if (|m[8:1]) begin
			add_code(codes[0]);
		end
		for (int k = 1; k <= 10; k++) begin
			if (m[k]) begin
				add_code(codes[k]);
			end
		end
		cnd <= {11'h0, m[10:2], 3'h0} | (m[1] ? 23'h1 << src : 23'h0);
		check_runs(2);
		cnd <= 23'h0;
		$display("morse test done, codes %h", m);
	endtask

	// Controller pattern on one input, held or pulsed
	task automatic pattern(input int b, input int reps, input bit pulse);
		quiet();
		cnd <= 23'h1 << b;
		if (pulse) begin
			repeat (3) @(posedge clk);
			cnd <= 23'h0;
		end
		check_runs(reps);
		cnd <= 23'h0;
		$display("pattern test done, input %0d", b);
	endtask

	// Prints the counts and the verdict, then stops
	task automatic end_of_test();
		$display("checks %0d, mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// Main sequence
	initial begin
		void'($urandom(32'hea52));
		repeat (12) @(posedge clk);
		arst_n <= 1'b1;
		@(negedge clk);
		`CHK(tone, 1'b0)
		// Reset values, unmapped place, ignored write
		rd_chk(OFS_STATUS, 32'h0);
		rd_chk(OFS_CTRL, 32'h1);
		wr(4'h3, 32'hffffffff);
		rd_chk(4'h2, 32'h0);
		rd_chk(OFS_MASK, 32'h0);
		// Interrupt raised, masked and cleared after a fan-letter (F) pass
		morse(10'h002, 0);
		quiet();
		rd_chk(OFS_STATUS, 32'h5);
		`CHK(irq, 1'b0)
		wr(OFS_MASK, 32'h1);
		repeat (3) @(negedge clk);
		`CHK(irq, 1'b1)
		wr(OFS_STATUS, 32'h1);
		rd_chk(OFS_STATUS, 32'h4);
		`CHK(irq, 1'b0)
		wr(OFS_MASK, 32'h7);
		wr(OFS_STATUS, 32'h7);
		rd_chk(OFS_STATUS, 32'h0);
		$display("register test done");
		// Corner codes: all, info only, noncrit only, SOS only
		morse(10'h3ff, 2);
		morse(10'h100, 0);
		morse(10'h200, 0);
		morse(10'h080, 1);
		repeat (4) begin
			morse(10'($urandom_range(1, 1023)), $urandom_range(0, 2));
		end
		// Disabled sequencer stays silent, then plays the init pattern
		quiet();
		wr(OFS_CTRL, 32'h0);
		cnd <= 23'h1 << 12;
		repeat (30) @(negedge clk);
		`CHK(buz_u.runs.size(), 0)
		wr(OFS_CTRL, 32'h1);
		cnd <= 23'h0;
		exp_q = '{BP, -W25, BP};
		pattern(12, 2, 1'b0);
		for (int b = 13; b <= 15; b++) begin
			exp_q = '{BP, -W75, BP, -W75, BP};
			pattern(b, 2, 1'b0);
		end
		for (int b = 16; b <= 18; b++) begin
			exp_q = '{BP, -W50, BP};
			pattern(b, 2, 1'b0);
		end
		// Notice patterns play exactly twice
		quiet();
		wr(OFS_STATUS, 32'h7);
		for (int b = 19; b <= 22; b++) begin
			exp_q = '{BP, -W25, BP, -W50, BP, -W75, BP, -W100, BP, -W125, BP};
			pattern(b, 2, 1'b1);
			repeat (60) @(negedge clk);
			`CHK(buz_u.runs.size(), 24)
		end
		rd_chk(OFS_STATUS, 32'h6);
		end_of_test();
	end
endmodule
